// ### rtl/lsnseq_linemap.sv
// Routes receiver events onto signal lines 0 to 4, registered
`timescale 1ns/1ns
`include "lsnseq_map.svh"
module lsnseq_linemap (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Mapping
    input  wire logic [9:0] line_map,
    input  wire logic       preamble_map_select,
    // Events
    input  wire logic       crc_good_event,
    input  wire logic       payload_complete_event,
    input  wire logic       fifo_threshold_event,
    input  wire logic       fifo_drained_event,
    input  wire logic       sync_word_match_event,
    input  wire logic       preamble_found_event,
    // Lines
    output logic [4:0]      signal_line
);
    logic [4:0] line_next;

    // Small fixed selection per line; unlisted codes drive low
    always_comb begin
        line_next = 5'h00;
        case (line_map[1:0])
            2'h0:    line_next[0] = payload_complete_event;
            2'h1:    line_next[0] = crc_good_event;
            default: line_next[0] = 1'b0;
        endcase
        line_next[1] = (line_map[3:2] == 2'h0) ? fifo_threshold_event : 1'b0;
        line_next[2] = (line_map[5:4] == `LSNSEQ_MAP_CODE_11)
                       ? sync_word_match_event : 1'b0;
        line_next[3] = (line_map[7:6] == 2'h0) ? fifo_drained_event : 1'b0;
        // Preamble routed only with code 11 and map bit set
        line_next[4] = (line_map[9:8] == `LSNSEQ_MAP_CODE_11)
                       && preamble_map_select && preamble_found_event;
    end

    // Registered so that the lines stay glitch free
    always_ff @(posedge clock) begin
        if (!nrst)
            signal_line <= 5'h00;
        else
            signal_line <= line_next;
    end
endmodule : lsnseq_linemap

// ### rtl/lsnseq_map.svh
// Constants of the listen mode sequencer: encodings, timing and reset values
`ifndef LSNSEQ_MAP_SVH
`define LSNSEQ_MAP_SVH

// Start transition codes
`define LSNSEQ_START_TO_LOWPWR  2'h0
// Low power target code
`define LSNSEQ_LOWPWR_TO_IDLE  1'h1
// Idle exit codes
`define LSNSEQ_IDLE_TO_RX      1'h1
// Receive exit codes
`define LSNSEQ_RX_OFF_PAYLOAD  3'h4
`define LSNSEQ_RX_OFF_SYNC     3'h5
`define LSNSEQ_RX_OFF_PREAMBLE 3'h6
// Receive timeout exit code
`define LSNSEQ_TMO_TO_LOWPWR   2'h2
// Signal line map codes
`define LSNSEQ_MAP_CODE_11     2'h3
`define LSNSEQ_MAP_CODE_01     2'h1
// Timer width and reset value
`define LSNSEQ_TMR_W           16
`define LSNSEQ_TMR_RST         16'h0001
// Interrupt request pulse stretch, in ns and cycles at 100 MHz
`define LSNSEQ_IRQ_NS          20
`define LSNSEQ_CLK_NS          10
`define LSNSEQ_IRQ_CYC ((`LSNSEQ_IRQ_NS + `LSNSEQ_CLK_NS - 1) / `LSNSEQ_CLK_NS)

`endif

// ### rtl/lsnseq_pkg.sv
// Types of the listen mode sequencer
package lsnseq_pkg;
    typedef enum logic [2:0] {
        LSNSEQ_OFF,
        LSNSEQ_LOWPWR,
        LSNSEQ_IDLE,
        LSNSEQ_RX,
        LSNSEQ_HOLD
    } lsnseq_state_t;
endpackage : lsnseq_pkg

// ### rtl/lsnseq_timer.sv
// Down counter ticking on the RC oscillator tick, one-cycle expiry pulse
`timescale 1ns/1ns
module lsnseq_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] period,
    input  wire logic         tick,
    // Status
    output logic              expired
);
    logic [W-1:0] count_reg;
    logic         run_reg;

    // Load restarts the count; expiry stops it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
            expired   <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                count_reg <= period;
                run_reg   <= 1'b1;
            end else if (run_reg && tick) begin
                if (count_reg <= W'(1)) begin
                    run_reg <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count_reg <= count_reg - W'(1);
                end
            end
        end
    end
endmodule : lsnseq_timer

// ### rtl/lsnseq_top.sv
// Listen mode top sequencer: idle/receive polling with wake detection
`timescale 1ns/1ns
`include "lsnseq_map.svh"
module lsnseq_top #(
    parameter int TW = `LSNSEQ_TMR_W
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // Host control
    input  wire logic          seq_start,
    input  wire logic          seq_stop,
    input  wire logic          idle_state_select,
    input  wire logic [1:0]    start_transition_sel,
    input  wire logic          low_power_target_sel,
    input  wire logic          idle_exit_transition_sel,
    input  wire logic [2:0]    receive_exit_transition_sel,
    input  wire logic [1:0]    timeout_exit_sel,
    input  wire logic [TW-1:0] idle_interval_timer,
    input  wire logic [TW-1:0] receive_window_timer,
    input  wire logic [TW-1:0] receive_timeout_interval,
    input  wire logic [9:0]    line_map,
    input  wire logic          preamble_map_select,
    // RC oscillator tick, from another domain
    input  wire logic          rc_tick_pin,
    // Receiver events, same clock
    input  wire logic          preamble_found_event,
    input  wire logic          sync_word_match_event,
    input  wire logic          payload_complete_event,
    input  wire logic          crc_good_event,
    input  wire logic          fifo_threshold_event,
    input  wire logic          fifo_drained_event,
    // Status
    output logic               receiver_on,
    output logic               sleep_on,
    output logic               seq_running,
    output logic               irq_packet,
    output logic [4:0]         signal_line
);
    localparam logic [1:0] IRQ_CYC = 2'(`LSNSEQ_IRQ_CYC);

    lsnseq_pkg::lsnseq_state_t state_reg;
    lsnseq_pkg::lsnseq_state_t state_next;
    logic                      tick_s1_reg;
    logic                      tick_s2_reg;
    logic                      tick_d_reg;
    logic                      tick;
    logic                      t1_load;
    logic                      t2_load;
    logic                      tmo_load;
    logic                      t1_exp;
    logic                      t2_exp;
    logic                      tmo_exp;
    logic                      pre_seen_reg;
    logic                      rest_reg;
    logic                      wake_hit;
    logic                      sync_mode;
    logic [1:0]                irq_cnt_reg;

    // Two-stage synchroniser for the RC tick, edge taken after stage two
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tick_s1_reg <= 1'b0;
            tick_s2_reg <= 1'b0;
            tick_d_reg  <= 1'b0;
        end else begin
            tick_s1_reg <= rc_tick_pin;
            tick_s2_reg <= tick_s1_reg;
            tick_d_reg  <= tick_s2_reg;
        end
    end
    assign tick = tick_s2_reg && !tick_d_reg;

    // Idle interval timer runs during idle
    lsnseq_timer #(.W(TW)) u_idle_tmr (
        .clock   (clock),
        .nrst    (nrst),
        .load    (t1_load),
        .period  (idle_interval_timer),
        .tick    (tick),
        .expired (t1_exp)
    );

    // Receive window timer runs during receive
    lsnseq_timer #(.W(TW)) u_win_tmr (
        .clock   (clock),
        .nrst    (nrst),
        .load    (t2_load),
        .period  (receive_window_timer),
        .tick    (tick),
        .expired (t2_exp)
    );

    // Short receive timeout used in every wake mode but preamble
    lsnseq_timer #(.W(TW)) u_tmo_tmr (
        .clock   (clock),
        .nrst    (nrst),
        .load    (tmo_load),
        .period  (receive_timeout_interval),
        .tick    (tick),
        .expired (tmo_exp)
    );

    // Wake criterion picked by the receive exit code
    always_comb begin
        case (receive_exit_transition_sel)
            `LSNSEQ_RX_OFF_PREAMBLE: wake_hit = preamble_found_event;
            // Sync word ends the polling
            `LSNSEQ_RX_OFF_SYNC:     wake_hit = sync_word_match_event;
            `LSNSEQ_RX_OFF_PAYLOAD:  wake_hit = payload_complete_event;
            default:                 wake_hit = 1'b0;
        endcase
    end
    assign sync_mode = (receive_exit_transition_sel != `LSNSEQ_RX_OFF_PREAMBLE);

    // Next state of the polling loop
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lsnseq_pkg::LSNSEQ_OFF: begin
                if (seq_start &&
                    start_transition_sel == `LSNSEQ_START_TO_LOWPWR)
                    state_next = lsnseq_pkg::LSNSEQ_LOWPWR;
            end
            lsnseq_pkg::LSNSEQ_LOWPWR: begin
                // Low power selection chooses the idle phase
                if (rest_reg && !t2_exp)
                    state_next = lsnseq_pkg::LSNSEQ_LOWPWR;
                else if (low_power_target_sel == `LSNSEQ_LOWPWR_TO_IDLE)
                    state_next = lsnseq_pkg::LSNSEQ_IDLE;
                else
                    state_next = lsnseq_pkg::LSNSEQ_OFF;
            end
            lsnseq_pkg::LSNSEQ_IDLE: begin
                // Wake receiver on idle timer expiry
                if (t1_exp && idle_exit_transition_sel == `LSNSEQ_IDLE_TO_RX)
                    state_next = lsnseq_pkg::LSNSEQ_RX;
            end
            lsnseq_pkg::LSNSEQ_RX: begin
                if (wake_hit)
                    state_next = lsnseq_pkg::LSNSEQ_HOLD;
                else if (t2_exp)
                    state_next = lsnseq_pkg::LSNSEQ_LOWPWR;
                else if (sync_mode && tmo_exp && !pre_seen_reg &&
                         timeout_exit_sel == `LSNSEQ_TMO_TO_LOWPWR)
                    state_next = lsnseq_pkg::LSNSEQ_LOWPWR;
            end
            lsnseq_pkg::LSNSEQ_HOLD: begin
                state_next = lsnseq_pkg::LSNSEQ_HOLD;
            end
            default: state_next = lsnseq_pkg::LSNSEQ_OFF;
        endcase
        // Host stop ends everything
        if (seq_stop)
            state_next = lsnseq_pkg::LSNSEQ_OFF;
    end

    // State register
    always_ff @(posedge clock) begin
        if (!nrst)
            state_reg <= lsnseq_pkg::LSNSEQ_OFF;
        else
            state_reg <= state_next;
    end

    // Timer loads on phase entry; window counts from receive start,
    // so a receive starts every idle plus window
    assign t1_load  = (state_reg != lsnseq_pkg::LSNSEQ_IDLE) &&
                      (state_next == lsnseq_pkg::LSNSEQ_IDLE);
    assign t2_load  = (state_reg != lsnseq_pkg::LSNSEQ_RX) &&
                      (state_next == lsnseq_pkg::LSNSEQ_RX);
    assign tmo_load = t2_load;

    // Preamble seen in this window keeps receive past timeout
    always_ff @(posedge clock) begin
        if (!nrst)
            pre_seen_reg <= 1'b0;
        else if (state_reg != lsnseq_pkg::LSNSEQ_RX)
            pre_seen_reg <= 1'b0;
        else if (preamble_found_event)
            pre_seen_reg <= 1'b1;
    end

    // Window remainder owed after a receive timeout; without it the
    // period would shrink to idle plus timeout
    always_ff @(posedge clock) begin
        if (!nrst)
            rest_reg <= 1'b0;
        else if (state_reg == lsnseq_pkg::LSNSEQ_RX && !t2_exp &&
                 state_next == lsnseq_pkg::LSNSEQ_LOWPWR)
            rest_reg <= 1'b1;
        else if (t2_exp || state_next == lsnseq_pkg::LSNSEQ_OFF)
            rest_reg <= 1'b0;
    end

    // Phase outputs: receiver off outside receive and hold
    always_ff @(posedge clock) begin
        if (!nrst) begin
            receiver_on <= 1'b0;
            sleep_on    <= 1'b0;
            seq_running <= 1'b0;
        end else begin
            receiver_on <= (state_next == lsnseq_pkg::LSNSEQ_RX) ||
                           (state_next == lsnseq_pkg::LSNSEQ_HOLD);
            // Sleep with RC on while idle or in low power
            sleep_on    <= idle_state_select &&
                           (state_next == lsnseq_pkg::LSNSEQ_IDLE ||
                            state_next == lsnseq_pkg::LSNSEQ_LOWPWR);
            seq_running <= (state_next != lsnseq_pkg::LSNSEQ_OFF) &&
                           (state_next != lsnseq_pkg::LSNSEQ_HOLD);
        end
    end

    // Packet interrupt stretched to a fixed width
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_cnt_reg <= 2'h0;
            irq_packet  <= 1'b0;
        end else begin
            if (payload_complete_event && state_reg != lsnseq_pkg::LSNSEQ_OFF)
                irq_cnt_reg <= IRQ_CYC;
            else if (irq_cnt_reg != 2'h0)
                irq_cnt_reg <= irq_cnt_reg - 2'h1;
            irq_packet <= (payload_complete_event &&
                           state_reg != lsnseq_pkg::LSNSEQ_OFF) ||
                          (irq_cnt_reg > 2'h1);
        end
    end

    // Signal line routing
    lsnseq_linemap u_linemap (
        .clock                  (clock),
        .nrst                   (nrst),
        .line_map               (line_map),
        .preamble_map_select    (preamble_map_select),
        .crc_good_event         (crc_good_event),
        .payload_complete_event (payload_complete_event),
        .fifo_threshold_event   (fifo_threshold_event),
        .fifo_drained_event     (fifo_drained_event),
        .sync_word_match_event  (sync_word_match_event),
        .preamble_found_event   (preamble_found_event),
        .signal_line            (signal_line)
    );
endmodule : lsnseq_top

// ### sim/lsnseq_front_model.sv
// Far-side model: free-running RC oscillator and receive detectors
`timescale 1ns/1ns
module lsnseq_front_model #(
    parameter int RC_HALF_NS = 85
) (
    // Clock and receiver state
    input  wire logic clock,
    input  wire logic receiver_on,
    // Bench requests
    input  wire logic want_pre,
    input  wire logic want_sync,
    // Toward the sequencer
    output logic      rc_tick_pin,
    output logic      preamble_found_event,
    output logic      sync_word_match_event
);
    logic [3:0] lock_cnt;
    logic       pre_seen;
    // RC oscillator runs free; offset keeps its phase off the clock edges
    initial begin
        rc_tick_pin = 1'b0;
        #3;
        forever #(RC_HALF_NS) rc_tick_pin = ~rc_tick_pin;
    end
    // Nothing is detected while the receiver is off, however long the air
    always_ff @(posedge clock) begin
        lock_cnt <= receiver_on ? lock_cnt + 4'h1 : 4'h0;
        preamble_found_event <= receiver_on && want_pre && lock_cnt == 4'h4;
        pre_seen <= receiver_on && (pre_seen || preamble_found_event);
        sync_word_match_event <= receiver_on && want_sync && pre_seen
                                 && lock_cnt == 4'h9;
    end
endmodule : lsnseq_front_model

// ### sim/lsnseq_top_asserts.sv
// Port assertions for the listen mode sequencer
`timescale 1ns/1ns
module lsnseq_top_asserts (
    // Clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // Host control and events
    input wire logic       seq_start,
    input wire logic       seq_stop,
    input wire logic       idle_state_select,
    input wire logic [1:0] start_transition_sel,
    input wire logic [2:0] receive_exit_transition_sel,
    input wire logic [9:0] line_map,
    input wire logic       preamble_map_select,
    input wire logic       preamble_found_event,
    input wire logic       sync_word_match_event,
    input wire logic       payload_complete_event,
    // Status
    input wire logic       receiver_on,
    input wire logic       sleep_on,
    input wire logic       seq_running,
    input wire logic       irq_packet,
    input wire logic [4:0] signal_line
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Receive phase: running with receiver on
    wire in_rx  = seq_running && receiver_on && !seq_stop;
    wire in_off = !seq_running && !receiver_on;
    // Sequencer stops and keeps receiving on the configured event
    pre_stop_a: assert property (in_rx && preamble_found_event &&
        receive_exit_transition_sel == 3'h6 |=> receiver_on && !seq_running)
        else $error("preamble did not stop the sequencer");
    sync_stop_a: assert property (in_rx && sync_word_match_event &&
        receive_exit_transition_sel == 3'h5 |=> receiver_on && !seq_running)
        else $error("sync word did not stop the sequencer");
    hold_stays_a: assert property (receiver_on && !seq_running
        && !seq_stop |=> receiver_on && !seq_running)
        else $error("receive hold left without host");
    stop_off_a: assert property (seq_stop |=> in_off)
        else $error("stop did not switch the sequencer off");
    rx_sleep_a: assert property (!(receiver_on && sleep_on))
        else $error("receiver on while asleep");
    start_a: assert property (in_off && seq_start && !seq_stop
        && start_transition_sel == 2'h0
        |=> seq_running && !receiver_on
        && sleep_on == $past(idle_state_select))
        else $error("start did not enter low power");
    start_ign_a: assert property (in_off
        && start_transition_sel != 2'h0 |=> !seq_running)
        else $error("start ran with a wrong start code");
    irq_pkt_a: assert property (payload_complete_event
        && seq_stop == 1'b0 && (seq_running || receiver_on)
        |-> ##[1:2] irq_packet)
        else $error("no packet interrupt");
    line4_a: assert property (preamble_found_event
        && preamble_map_select && line_map[9:8] == 2'h3 |=> signal_line[4])
        else $error("preamble not on signal line 4");
    // Main scenarios
    cov_pre: cover property (in_rx && preamble_found_event ##1 !seq_running);
    cov_sync: cover property (in_rx && sync_word_match_event);
    cov_poll: cover property ($fell(receiver_on) && seq_running);
endmodule : lsnseq_top_asserts
bind lsnseq_top lsnseq_top_asserts u_asserts (.*);

// ### sim/testbench.sv
// Self-checking bench for the listen mode sequencer
`timescale 1ns/1ns
module testbench;
    localparam int RC = 17;  // RC tick period in clocks
    logic        clock, nrst, seq_start, seq_stop, idle_state_select;
    logic [1:0]  start_transition_sel, timeout_exit_sel;
    logic        low_power_target_sel, idle_exit_transition_sel;
    logic [2:0]  receive_exit_transition_sel;
    logic [15:0] idle_interval_timer, receive_window_timer;
    logic [15:0] receive_timeout_interval;
    logic [9:0]  line_map;
    logic        preamble_map_select, rc_tick_pin, preamble_found_event;
    logic        sync_word_match_event, payload_complete_event;
    logic        crc_good_event, fifo_threshold_event, fifo_drained_event;
    logic        receiver_on, sleep_on, seq_running, irq_packet;
    logic [4:0]  signal_line;
    logic        want_pre, want_sync, seen2, seen4;
    int          n_errors, samples_checked, cyc;
    // Device and far side
    lsnseq_top u_dut (.*);
    lsnseq_front_model u_front (.clock(clock), .receiver_on(receiver_on),
        .want_pre(want_pre), .want_sync(want_sync),
        .rc_tick_pin(rc_tick_pin),
        .preamble_found_event(preamble_found_event),
        .sync_word_match_event(sync_word_match_event));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard and line watchers
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (signal_line[4] === 1'b1) seen4 = 1'b1;
        if (signal_line[2] === 1'b1) seen2 = 1'b1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic chk_rng(string nm, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d",
                     nm, lo, hi, got);
        end
    endtask : chk_rng
    task automatic cyc_n(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc_n
    // Bounded wait for the receiver to reach a level, counting clocks
    task automatic wait_rx(logic v, output int n);
        n = 0;
        while (receiver_on !== v && n < 2000) begin
            cyc_n(1);
            n++;
        end
    endtask : wait_rx
    // Stop, program one wake mode and start the sequencer
    task automatic run(logic [2:0] ex, logic [15:0] ti, logic [15:0] tw);
        seq_stop = 1'b1;
        want_pre = 1'b0;
        want_sync = 1'b0;
        cyc_n(1);
        seq_stop = 1'b0;
        seen2 = 1'b0;
        seen4 = 1'b0;
        receive_exit_transition_sel = ex;
        idle_interval_timer = ti;
        receive_window_timer = tw;
        seq_start = 1'b1;
        cyc_n(1);
        seq_start = 1'b0;
        chk("running", 1, seq_running);
        chk("sleep", 1, sleep_on);
    endtask : run
    // No signal: window length, idle length, and the loop repeats
    task automatic t_poll;
        int n;
        run(3'h6, 16'h0003, 16'h0002);
        wait_rx(1'b1, n);
        wait_rx(1'b0, n);
        chk_rng("rx_len", RC, 2 * RC + 4, n);
        cyc_n(1);
        chk("idle_sleep", 1, sleep_on);
        wait_rx(1'b1, n);
        chk_rng("idle_len", 2 * RC, 3 * RC + 6, n);
        chk("still_run", 1, seq_running);
    endtask : t_poll
    // Preamble wake holds receive; packet raises interrupt and lines
    task automatic t_pre_wake;
        int n;
        run(3'h6, 16'h0003, 16'h0002);
        want_pre = 1'b1; // Preamble longer than idle plus two windows
        wait_rx(1'b1, n);
        cyc_n(5 * RC);
        chk("hold_rx", 1, receiver_on);
        chk("hold_stop", 0, seq_running);
        chk("line4", 1, seen4);
        payload_complete_event = 1'b1;
        crc_good_event = 1'b1;
        {fifo_threshold_event, fifo_drained_event} = 2'h3;
        cyc_n(1);
        payload_complete_event = 1'b0;
        crc_good_event = 1'b0;
        {fifo_threshold_event, fifo_drained_event} = 2'h0;
        chk("line0_crc", 1, signal_line[0]);
        chk("line1_fifo", 1, signal_line[1]);
        chk("line3_empty", 1, signal_line[3]);
        chk("irq_first", 1, irq_packet);
        cyc_n(1);
        chk("irq", 1, irq_packet);
        chk("line0_off", 0, signal_line[0]);
        cyc_n(1);
        chk("irq_end", 0, irq_packet);
    endtask : t_pre_wake
    // Sync mode: short wake alone, full window after a lone preamble
    task automatic t_sync_none;
        int n;
        run(3'h5, 16'h0003, 16'h0004);
        wait_rx(1'b1, n);
        wait_rx(1'b0, n);
        chk_rng("tmo_len", RC, 2 * RC + 4, n);
        want_pre = 1'b1;
        wait_rx(1'b1, n);
        chk_rng("rest_len", 5 * RC - 2, 5 * RC + 2, n);
        wait_rx(1'b0, n);
        chk_rng("win_len", 3 * RC, 4 * RC + 4, n);
        chk("resumed", 1, seq_running);
    endtask : t_sync_none
    // Sync mode: preamble then sync word stops the sequencer
    task automatic t_sync_wake;
        int n;
        run(3'h5, 16'h0003, 16'h0004);
        want_pre = 1'b1;
        want_sync = 1'b1;
        wait_rx(1'b1, n);
        cyc_n(8 * RC);
        chk("sync_hold", 1, receiver_on);
        chk("sync_stop", 0, seq_running);
        chk("line2", 1, seen2);
        seq_stop = 1'b1;
        cyc_n(1);
        seq_stop = 1'b0;
        chk("host_off", 0, receiver_on);
    endtask : t_sync_wake
    // A start code other than 00 leaves the sequencer off
    task automatic t_bad_start;
        start_transition_sel = 2'h1;
        seq_start = 1'b1;
        cyc_n(3);
        seq_start = 1'b0;
        chk("bad_start", 0, seq_running);
        start_transition_sel = 2'h0;
    endtask : t_bad_start
    // Rare settings: low power to off, idle kept, payload wake
    task automatic t_modes;
        int n;
        low_power_target_sel = 1'b0;
        run(3'h6, 16'h0003, 16'h0002);
        cyc_n(1);
        chk("lp_off", 0, seq_running);
        low_power_target_sel = 1'b1;
        idle_exit_transition_sel = 1'b0;
        run(3'h6, 16'h0003, 16'h0002);
        cyc_n(4 * RC);
        chk("idle_kept", 0, receiver_on);
        idle_exit_transition_sel = 1'b1;
        run(3'h4, 16'h0003, 16'h0002);
        wait_rx(1'b1, n);
        payload_complete_event = 1'b1;
        cyc_n(1);
        payload_complete_event = 1'b0;
        chk("pay_stop", 0, seq_running);
        chk("pay_hold", 1, receiver_on);
    endtask : t_modes
    initial begin
        {seq_start, seq_stop, want_pre, want_sync, cyc} = '0;
        {n_errors, samples_checked, seen2, seen4} = '0;
        {payload_complete_event, crc_good_event} = 2'h0;
        {fifo_threshold_event, fifo_drained_event} = 2'h0;
        idle_state_select = 1'b1; // Host settings
        start_transition_sel = 2'h0;
        low_power_target_sel = 1'b1;
        idle_exit_transition_sel = 1'b1;
        timeout_exit_sel = 2'h2;
        receive_exit_transition_sel = 3'h6;
        idle_interval_timer = 16'h0003; // Long idle, short window
        receive_window_timer = 16'h0002;
        receive_timeout_interval = 16'h0002;
        line_map = {2'h3, 2'h0, 2'h3, 2'h0, 2'h1};
        preamble_map_select = 1'b1;
        nrst = 1'b0;
        cyc_n(8);
        nrst = 1'b1;
        cyc_n(3);
        t_bad_start();
        t_poll();
        t_pre_wake();
        t_sync_none();
        t_sync_wake();
        t_modes();
        end_sim();
    end
endmodule : testbench
